// ===== rsu_mem.sv
// word-addressed data memory that answers the unit's requests
`timescale 1ns/1ns
module rsu_mem (
    input  wire logic        clk,
    input  wire logic        mem_req,
    input  wire logic        mem_we,
    input  wire logic [15:0] mem_addr,
    input  wire logic [15:0] mem_wdata,
    input  wire logic [1:0]  slow,
    output logic      [15:0] mem_rdata,
    output logic             mem_ack
);
    logic [15:0] mem [0:65535];
    logic [1:0]  wait_q = 2'h0;
    int          wseed  = 32'hfb9e;

    initial begin
        mem_ack = 1'b0;
        mem_rdata = 16'h0000;
    end

    // one-cycle ack after a random wait; read data only valid with ack
    always @(posedge clk) begin
        mem_ack <= 1'b0;
        mem_rdata <= ~mem_rdata;
        if (mem_req && mem_ack && mem_we) begin
            mem[mem_addr] <= mem_wdata;
        end else if (mem_req && !mem_ack) begin
            if (wait_q == 2'h0) begin
                mem_ack <= 1'b1;
                mem_rdata <= mem[mem_addr];
                wait_q <= 2'($random(wseed)) & slow;
            end else begin
                wait_q <= wait_q - 2'h1;
            end
        end
    end
endmodule

// ===== rsu_pkg.sv
// constants, types and register map of the range summation unit
// Operation
// - idle while execution condition false
// - item count from three BCD digits
// - count means words or bytes
// - add items, write total to two words
// - total in same number form
// - control bit 13 selects byte units
// - bit 12 skips first high byte
// - bytes summed high then low per word
// - bit 14 binary, bit 15 signed in binary mode only
// - bit 14 clear means BCD
// - bad item count sets fault
// - range across areas sets fault
// - non-BCD item in BCD mode faults
// - bad indirect pointer sets fault
// - zero flag reflects zero total
package rsu_pkg;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] RSU_OFF_CTRL  = 8'h00;
    localparam logic [7:0] RSU_OFF_START = 8'h04;
    localparam logic [7:0] RSU_OFF_DEST  = 8'h08;
    localparam logic [7:0] RSU_OFF_CFG   = 8'h0c;
    localparam logic [7:0] RSU_OFF_GO    = 8'h10;
    localparam logic [7:0] RSU_OFF_STAT  = 8'h14;
    localparam logic [7:0] RSU_OFF_RES   = 8'h18;
    localparam logic [7:0] RSU_OFF_ISTAT = 8'h1c;
    localparam logic [7:0] RSU_OFF_IMASK = 8'h20;

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int RSU_BIT_SKIP   = 12;
    localparam int RSU_BIT_BYTE   = 13;
    localparam int RSU_BIT_BIN    = 14;
    localparam int RSU_BIT_SIGNED = 15;

    // status and interrupt bits
    localparam int RSU_ST_BUSY  = 0;
    localparam int RSU_ST_FAULT = 1;
    localparam int RSU_ST_ZERO  = 2;
    localparam int RSU_IRQ_DONE = 0;
    localparam int RSU_IRQ_ERR  = 1;

    // ------------------------------------------------------------
    // memory areas and reset values
    // ------------------------------------------------------------
    localparam int          RSU_AREA_LSB   = 13;
    localparam int          RSU_AREA_WORDS = 8192;
    localparam logic [15:0] RSU_DM_BASE    = 16'h8000;
    localparam logic [15:0] RSU_RST_CTRL   = 16'h0000;
    localparam logic [1:0]  RSU_RST_IMASK  = 2'h0;

    typedef enum logic [6:0] {
        RSU_S_IDLE  = 7'h01,
        RSU_S_PTR   = 7'h02,
        RSU_S_CHECK = 7'h04,
        RSU_S_READ  = 7'h08,
        RSU_S_ITEM  = 7'h10,
        RSU_S_WLO   = 7'h20,
        RSU_S_WHI   = 7'h40
    } rsu_state_t;

endpackage

// ===== rsu_range_sum_unit.sv
// range summation unit: apb registers, memory sequencer and adder
`timescale 1ns/1ns
module rsu_range_sum_unit
    import rsu_pkg::*;
#(
    parameter int DM_SIZE = 6656
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        exec_cond,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mem_req,
    output logic             mem_we,
    output logic      [15:0] mem_addr,
    output logic      [15:0] mem_wdata,
    input  wire logic [15:0] mem_rdata,
    input  wire logic        mem_ack,
    output logic             fault_indicator,
    output logic             zero_result_flag,
    output logic             irq
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (DM_SIZE < 1 || DM_SIZE > RSU_AREA_WORDS) begin : g_chk
        $error("DM_SIZE must fit one memory area");
    end

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic is_bcd16(input logic [15:0] x);
        return (x[3:0] <= 4'h9) && (x[7:4] <= 4'h9) && (x[11:8] <= 4'h9)
            && (x[15:12] <= 4'h9);
    endfunction

    function automatic logic [31:0] bcd_add32(input logic [31:0] a, input logic [31:0] b);
        logic [4:0]  s;
        logic        c;
        logic [31:0] r;
        c = 1'b0;
        r = 32'h0000_0000;
        for (int i = 0; i < 8; i++) begin
            s = {1'b0, a[4*i +: 4]} + {1'b0, b[4*i +: 4]} + {4'h0, c};
            if (s > 5'h09) begin
                s = s + 5'h06;
                c = 1'b1;
            end else begin
                c = 1'b0;
            end
            r[4*i +: 4] = s[3:0];
        end
        return r;
    endfunction

    function automatic logic [13:0] bcd4_to_bin(input logic [15:0] x);
        return {10'h000, x[15:12]} * 14'h03e8 + {10'h000, x[11:8]} * 14'h0064
            + {10'h000, x[7:4]} * 14'h000a + {10'h000, x[3:0]};
    endfunction

    function automatic logic [2:0] area_of(input logic [15:0] a);
        return a[15:RSU_AREA_LSB];
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        rsu_state_t  st;
        logic [15:0] ctrl;
        logic [15:0] start;
        logic [15:0] dest;
        logic        ind;
        logic [15:0] addr;
        logic [9:0]  rem;
        logic        half;
        logic [15:0] word;
        logic [31:0] acc;
        logic [31:0] result;
        logic        fault;
        logic        zero;
        logic [1:0]  ist;
        logic [1:0]  imask;
        logic        irq;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        mem_req;
        logic        mem_we;
        logic [15:0] mem_addr;
        logic [15:0] mem_wdata;
    } rsu_regs_t;

    rsu_regs_t q;
    rsu_regs_t d;

    // ------------------------------------------------------------
    // operand decode
    // ------------------------------------------------------------
    logic        byte_mode;
    logic        bin_mode;
    logic        sgn_mode;
    logic        skip_hi;
    logic [9:0]  cnt_bin;
    logic        cnt_ok;
    logic [16:0] last_addr;
    logic        area_ok;
    logic [13:0] ptr_bin;
    logic        ptr_ok;
    logic [7:0]  cur_byte;
    logic [15:0] item;
    logic        item_bcd;
    logic [31:0] addend;
    logic [31:0] acc_next;

    assign byte_mode = q.ctrl[RSU_BIT_BYTE];
    assign bin_mode  = q.ctrl[RSU_BIT_BIN];
    assign sgn_mode  = q.ctrl[RSU_BIT_BIN] & q.ctrl[RSU_BIT_SIGNED];
    assign skip_hi   = byte_mode & q.ctrl[RSU_BIT_SKIP];
    assign cnt_bin   = {6'h00, q.ctrl[11:8]} * 10'h064 + {6'h00, q.ctrl[7:4]} * 10'h00a
                     + {6'h00, q.ctrl[3:0]};
    assign cnt_ok    = is_bcd16({4'h0, q.ctrl[11:0]}) && (cnt_bin != 10'h000);
    // byte span is (count + skip) / 2 words, rounded up
    assign last_addr = {1'b0, q.addr} + (byte_mode
                     ? {7'h00, (cnt_bin - 10'h001 + {9'h000, skip_hi}) >> 1}
                     : {7'h00, cnt_bin - 10'h001});
    assign area_ok   = !last_addr[16] && (area_of(q.addr) == area_of(last_addr[15:0]));
    assign ptr_bin   = bcd4_to_bin(mem_rdata);
    assign ptr_ok    = is_bcd16(mem_rdata) && ({18'h00000, ptr_bin} < DM_SIZE);

    // high byte first, then low byte
    assign cur_byte  = q.half ? q.word[7:0] : q.word[15:8];
    assign item      = byte_mode ? {8'h00, cur_byte} : q.word;
    assign item_bcd  = is_bcd16(item);

    always_comb begin
        if (sgn_mode && byte_mode) begin
            addend = {{24{cur_byte[7]}}, cur_byte};
        end else if (sgn_mode) begin
            addend = {{16{item[15]}}, item};
        end else begin
            addend = {16'h0000, item};
        end
    end

    // binary or decimal accumulation keeps the input number form
    assign acc_next = bin_mode ? q.acc + addend : bcd_add32(q.acc, addend);

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic apb_setup;
    logic apb_done;
    logic go;
    logic ev_done;
    logic ev_err;

    assign apb_setup = psel && penable && !q.pready;
    assign apb_done  = psel && penable && q.pready;
    assign go = apb_done && pwrite && (paddr == RSU_OFF_GO) && pwdata[0]
             && exec_cond && (q.st == RSU_S_IDLE);

    always_comb begin
        d       = q;
        ev_done = 1'b0;
        ev_err  = 1'b0;

        // apb slave: answer one cycle into the access phase
        d.pready  = apb_setup;
        d.pslverr = 1'b0;
        if (apb_setup) begin
            d.pslverr = 1'b0;
            if (paddr == RSU_OFF_CTRL) begin
                d.prdata = {16'h0000, q.ctrl};
            end else if (paddr == RSU_OFF_START) begin
                d.prdata = {16'h0000, q.start};
            end else if (paddr == RSU_OFF_DEST) begin
                d.prdata = {16'h0000, q.dest};
            end else if (paddr == RSU_OFF_CFG) begin
                d.prdata = {31'h0, q.ind};
            end else if (paddr == RSU_OFF_GO) begin
                d.prdata = 32'h0000_0000;
            end else if (paddr == RSU_OFF_STAT) begin
                d.prdata = {29'h0, q.zero, q.fault, q.st != RSU_S_IDLE};
            end else if (paddr == RSU_OFF_RES) begin
                d.prdata = q.result;
            end else if (paddr == RSU_OFF_ISTAT) begin
                d.prdata = {30'h0, q.ist};
            end else if (paddr == RSU_OFF_IMASK) begin
                d.prdata = {30'h0, q.imask};
            end else begin
                d.prdata  = 32'h0000_0000;
                d.pslverr = 1'b1;
            end
        end
        if (apb_done && pwrite && (q.st == RSU_S_IDLE)) begin
            if (paddr == RSU_OFF_CTRL) begin
                d.ctrl = pwdata[15:0];
            end else if (paddr == RSU_OFF_START) begin
                d.start = pwdata[15:0];
            end else if (paddr == RSU_OFF_DEST) begin
                d.dest = pwdata[15:0];
            end else if (paddr == RSU_OFF_CFG) begin
                d.ind = pwdata[0];
            end
        end
        if (apb_done && pwrite && (paddr == RSU_OFF_IMASK)) begin
            d.imask = pwdata[1:0];
        end
        if (apb_done && !pwrite && (paddr == RSU_OFF_ISTAT)) begin
            d.ist = q.ist & ~q.prdata[1:0];
        end

        // sequencer
        case (q.st)
            RSU_S_IDLE: begin
                if (go) begin
                    d.addr = q.start;
                    if (q.ind) begin
                        d.st       = RSU_S_PTR;
                        d.mem_req  = 1'b1;
                        d.mem_we   = 1'b0;
                        d.mem_addr = q.start;
                    end else begin
                        d.st = RSU_S_CHECK;
                    end
                end
            end
            RSU_S_PTR: begin
                if (mem_ack) begin
                    d.mem_req = 1'b0;
                    if (ptr_ok) begin
                        d.addr = RSU_DM_BASE + {2'h0, ptr_bin};
                        d.st   = RSU_S_CHECK;
                    end else begin
                        ev_err = 1'b1;
                    end
                end
            end
            RSU_S_CHECK: begin
                if (!cnt_ok || !area_ok) begin
                    ev_err = 1'b1;
                end else begin
                    d.rem      = cnt_bin;
                    d.half     = skip_hi;
                    d.acc      = 32'h0000_0000;
                    d.st       = RSU_S_READ;
                    d.mem_req  = 1'b1;
                    d.mem_we   = 1'b0;
                    d.mem_addr = q.addr;
                end
            end
            RSU_S_READ: begin
                if (mem_ack) begin
                    d.mem_req = 1'b0;
                    d.word    = mem_rdata;
                    d.st      = RSU_S_ITEM;
                end
            end
            RSU_S_ITEM: begin
                if (!bin_mode && !item_bcd) begin
                    ev_err = 1'b1;
                end else begin
                    d.acc = acc_next;
                    d.rem = q.rem - 10'h001;
                    if (q.rem == 10'h001) begin
                        d.st        = RSU_S_WLO;
                        d.mem_req   = 1'b1;
                        d.mem_we    = 1'b1;
                        d.mem_addr  = q.dest;
                        d.mem_wdata = acc_next[15:0];
                    end else if (byte_mode && !q.half) begin
                        d.half = 1'b1;
                    end else begin
                        d.half     = 1'b0;
                        d.addr     = q.addr + 16'h0001;
                        d.st       = RSU_S_READ;
                        d.mem_req  = 1'b1;
                        d.mem_addr = q.addr + 16'h0001;
                    end
                end
            end
            RSU_S_WLO: begin
                if (mem_ack) begin
                    d.st        = RSU_S_WHI;
                    d.mem_addr  = q.dest + 16'h0001;
                    d.mem_wdata = q.acc[31:16];
                end
            end
            RSU_S_WHI: begin
                if (mem_ack) begin
                    d.mem_req = 1'b0;
                    d.mem_we  = 1'b0;
                    d.result  = q.acc;
                    d.fault   = 1'b0;
                    d.zero    = (q.acc == 32'h0000_0000);
                    d.st      = RSU_S_IDLE;
                    ev_done   = 1'b1;
                end
            end
            default: begin
                d.st = RSU_S_IDLE;
            end
        endcase

        // an error ends the run before any destination write
        if (ev_err) begin
            d.fault   = 1'b1;
            d.st      = RSU_S_IDLE;
            d.mem_req = 1'b0;
            d.mem_we  = 1'b0;
        end
        // events win over a read clear
        if (ev_done) begin
            d.ist[RSU_IRQ_DONE] = 1'b1;
        end
        if (ev_err) begin
            d.ist[RSU_IRQ_ERR] = 1'b1;
        end
        d.irq = |(d.ist & d.imask);
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q       <= '0;
            q.st    <= RSU_S_IDLE;
            q.ctrl  <= RSU_RST_CTRL;
            q.imask <= RSU_RST_IMASK;
        end else begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata           = q.prdata;
    assign pready           = q.pready;
    assign pslverr          = q.pslverr;
    assign mem_req          = q.mem_req;
    assign mem_we           = q.mem_we;
    assign mem_addr         = q.mem_addr;
    assign mem_wdata        = q.mem_wdata;
    assign fault_indicator  = q.fault;
    assign zero_result_flag = q.zero;
    assign irq              = q.irq;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    idle_hold_a: assert property ((q.st == RSU_S_IDLE) && !exec_cond |=>
        (q.st == RSU_S_IDLE) && $stable(q.fault) && $stable(q.zero))
        else $error("unit left idle without execution condition");
    count_err_a: assert property ((q.st == RSU_S_CHECK) && !cnt_ok |=>
        q.fault && (q.st == RSU_S_IDLE) && !q.mem_req)
        else $error("bad item count not flagged");
    area_err_a: assert property ((q.st == RSU_S_CHECK) && !area_ok |=>
        q.fault && (q.st == RSU_S_IDLE))
        else $error("range across areas not flagged");
    bcd_err_a: assert property ((q.st == RSU_S_ITEM) && !bin_mode && !item_bcd |=>
        q.fault && (q.st == RSU_S_IDLE))
        else $error("non decimal item not flagged");
    ptr_err_a: assert property ((q.st == RSU_S_PTR) && mem_ack && !ptr_ok |=>
        q.fault && (q.st == RSU_S_IDLE))
        else $error("bad pointer not flagged");
    zero_flag_a: assert property ((q.st == RSU_S_WHI) && mem_ack |=>
        (q.zero == (q.result == 32'h0000_0000)) && !q.fault)
        else $error("zero flag wrong after result");
    low_first_a: assert property ((q.st == RSU_S_WLO) |->
        mem_we && (mem_addr == q.dest) && (mem_wdata == q.acc[15:0]))
        else $error("low half not written to first word");
    err_nowrite_a: assert property ($rose(q.fault) |->
        !mem_req && ($past(q.st) != RSU_S_WHI))
        else $error("destination written on fault");
    byte_skip_a: assert property ((q.st == RSU_S_CHECK) && skip_hi
        && cnt_ok && area_ok |=> q.half && (q.st == RSU_S_READ))
        else $error("high byte not skipped");
    ptr_addr_a: assert property ((q.st == RSU_S_PTR) && mem_ack && ptr_ok |=>
        (q.addr == RSU_DM_BASE + {2'h0, $past(ptr_bin)}))
        else $error("pointer address wrong");

    word_bcd_c: cover property ((q.st == RSU_S_WHI) && mem_ack && !bin_mode && !byte_mode);
    byte_sgn_c: cover property ((q.st == RSU_S_WHI) && mem_ack && sgn_mode && byte_mode);
    fault_c:    cover property ($rose(q.fault));

endmodule

// ===== testbench.sv
// self-checking bench for the range summation unit
`timescale 1ns/1ns
module testbench;
    import rsu_pkg::*;
    localparam int DATA_WORDS = 6656;
    logic        clk = 1'b0, srst = 1'b1, exec_cond = 1'b0, se;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, last_res = 32'h0;
    logic        pready, pslverr, mem_req, mem_we, mem_ack;
    logic        fault_indicator, zero_result_flag, irq;
    logic [15:0] mem_addr, mem_wdata, mem_rdata;
    logic [1:0]  slow = 2'h0;
    int          miscompares = 0, checks = 0, seed = 32'hfb9e;

    always #50 clk = ~clk;

    rsu_range_sum_unit #(.DM_SIZE(DATA_WORDS)) rsu_range_sum_unit_i (
        .clk(clk), .srst(srst), .exec_cond(exec_cond), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .fault_indicator(fault_indicator), .zero_result_flag(zero_result_flag),
        .irq(irq));
    rsu_mem rsu_mem_i (
        .clk(clk), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .slow(slow), .mem_rdata(mem_rdata),
        .mem_ack(mem_ack));

    // ------------------------------------------------------------
    // reporting
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic hang;
        miscompares++;
        complete_run();
    endtask

    // ------------------------------------------------------------
    // expected values
    // ------------------------------------------------------------
    function automatic int bcd(input logic [15:0] v);
        int r = 0;
        for (int i = 3; i >= 0; i--) begin
            if (v[i*4 +: 4] > 4'h9) return -1;
            r = r * 10 + int'(v[i*4 +: 4]);
        end
        return r;
    endfunction
    function automatic logic [31:0] tobcd(input int v);
        logic [31:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i*4 +: 4] = 4'(v % 10);
            v = v / 10;
        end
        return r;
    endfunction
    function automatic logic [32:0] ref_total(input logic [15:0] c, s, input logic ind);
        int          n, k, t, p, dt;
        logic [31:0] bt;
        logic [15:0] w;
        logic [16:0] last;
        n = bcd({4'h0, c[11:0]});
        if (ind) begin
            p = bcd(rsu_mem_i.mem[s]);
            if (p < 0 || p >= DATA_WORDS) return {1'b1, 32'h0};
            s = RSU_DM_BASE + 16'(p);
        end
        if (n < 1) return {1'b1, 32'h0};
        k = int'(c[13] & c[12]);
        last = 17'(s) + 17'(c[13] ? (n + k - 1) / 2 : n - 1);
        if (last[16:13] != {1'b0, s[15:13]}) return {1'b1, 32'h0};
        bt = 32'h0;
        dt = 0;
        for (int i = k; i < n + k; i++) begin
            w = rsu_mem_i.mem[16'(s + 16'(c[13] ? i / 2 : i))];
            if (c[13]) w = {8'h00, (i % 2) ? w[7:0] : w[15:8]};
            t = bcd(w);
            if (!c[14] && t < 0) return {1'b1, 32'h0};
            dt += t;
            bt += !c[15] ? {16'h0, w} : c[13] ? {{24{w[7]}}, w[7:0]}
                : {{16{w[15]}}, w};
        end
        return {1'b0, c[14] ? bt : tobcd(dt)};
    endfunction

    // ------------------------------------------------------------
    // bus and run tasks
    // ------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (n == 20) hang();
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic run(input logic [15:0] c, s, input logic ind, input logic [15:0] ptr,
                       input int fill, input logic off);
        logic [32:0] e;
        logic [15:0] d0, d1, ef;
        logic [1:0]  mk;
        logic        z0;
        int          n;
        ef = ind ? RSU_DM_BASE + 16'(bcd(ptr)) : s;
        for (int i = 0; i < 1000; i++) begin
            rsu_mem_i.mem[16'(ef + 16'(i))] = fill == 1 ? 16'($random(seed))
                : fill == 2 ? 16'h0 : 16'(tobcd({$random(seed)} % 10000));
        end
        if (fill == 3) rsu_mem_i.mem[ef][3:0] = 4'hb;
        if (ind) rsu_mem_i.mem[s] = ptr;
        rsu_mem_i.mem[16'h7000] = 16'($random(seed));
        rsu_mem_i.mem[16'h7001] = 16'($random(seed));
        d0 = rsu_mem_i.mem[16'h7000];
        d1 = rsu_mem_i.mem[16'h7001];
        e = ref_total(c, s, ind);
        z0 = zero_result_flag;
        mk = 2'($random(seed));
        slow <= 2'($random(seed));
        apb(1, RSU_OFF_IMASK, {30'h0, mk});
        apb(1, RSU_OFF_CTRL, {16'h0, c});
        apb(1, RSU_OFF_START, {16'h0, s});
        apb(1, RSU_OFF_DEST, 32'h7000);
        apb(1, RSU_OFF_CFG, {31'h0, ind});
        if (off) begin
            exec_cond <= 1'b0;
            apb(1, RSU_OFF_GO, 32'h1);
            apb(0, RSU_OFF_STAT, 32'h0);
            chk("busy off", rd[0], 1'b0);
            chk("dest off", rsu_mem_i.mem[16'h7000], d0);
            exec_cond <= 1'b1;
        end
        apb(1, RSU_OFF_GO, 32'h1);
        if (!e[32]) apb(1, RSU_OFF_CTRL, {16'h0, ~c});
        for (n = 0; n < 3000; n++) begin
            apb(0, RSU_OFF_STAT, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        if (n == 3000) hang();
        chk("fault", fault_indicator, e[32]);
        chk("zero", zero_result_flag, e[32] ? z0 : (e[31:0] == 32'h0));
        chk("dest low", rsu_mem_i.mem[16'h7000], e[32] ? d0 : e[15:0]);
        chk("dest high", rsu_mem_i.mem[16'h7001], e[32] ? d1 : e[31:16]);
        apb(0, RSU_OFF_RES, 32'h0);
        if (!e[32]) last_res = e[31:0];
        chk("result", rd, last_res);
        chk("irq", irq, |(mk & {e[32], !e[32]}));
        apb(0, RSU_OFF_ISTAT, 32'h0);
        chk("irq status", rd, {30'h0, e[32], !e[32]});
        apb(0, RSU_OFF_ISTAT, 32'h0);
        chk("irq clear", {rd[1:0], irq}, 3'h0);
        apb(0, RSU_OFF_CTRL, 32'h0);
        chk("ctrl busy", rd, {16'h0, c});
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [15:0] c;
        int          n;
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        exec_cond <= 1'b1;
        @(posedge clk);
        chk("reset outs", {fault_indicator, zero_result_flag, irq, mem_req, pready}, 5'h0);
        apb(0, RSU_OFF_CTRL, 32'h0);
        chk("ctrl reset", rd, {16'h0, RSU_RST_CTRL});
        apb(0, RSU_OFF_IMASK, 32'h0);
        chk("mask reset", rd, {30'h0, RSU_RST_IMASK});
        apb(0, 8'h24, 32'h0);
        chk("unmapped", {se, rd[30:0]}, 32'h80000000);
        run(16'h0001, 16'h0100, 0, 0, 0, 1);
        run(16'h0999, 16'h0200, 0, 0, 0, 0);
        run(16'h3007, 16'h1000, 0, 0, 0, 0);
        run(16'h2008, 16'h1000, 0, 0, 0, 0);
        run(16'h4010, 16'h0100, 0, 0, 1, 0);
        run(16'hc010, 16'h0100, 0, 0, 1, 0);
        run(16'he005, 16'h0100, 0, 0, 1, 0);
        run(16'hf004, 16'h0100, 0, 0, 1, 0);
        run(16'h8003, 16'h0100, 0, 0, 0, 0);
        run(16'h0000, 16'h0100, 0, 0, 0, 0);
        run(16'h00a1, 16'h0100, 0, 0, 0, 1);
        run(16'h0005, 16'h0100, 0, 0, 3, 0);
        run(16'h0005, 16'h1ffe, 0, 0, 0, 0);
        run(16'h4003, 16'hfffe, 0, 0, 1, 0);
        run(16'h4004, 16'h0100, 0, 0, 2, 0);
        run(16'h0010, 16'h0040, 1, 16'h0123, 0, 0);
        run(16'h0010, 16'h0040, 1, 16'h6656, 0, 0);
        run(16'h0010, 16'h0040, 1, 16'h12a4, 0, 0);
        repeat (12) begin
            n = 1 + {$random(seed)} % 60;
            c = {4'($random(seed)), 12'(tobcd(n))};
            run(c, 16'h0400, 0, 0, {31'h0, c[14]}, 0);
        end
        complete_run();
    end

    initial begin
        #9000000;
        hang();
    end
endmodule
